// file: src/exv_consts.svh
// Constants for the exception vector and register bank unit.
`ifndef EXV_CONSTS_SVH
`define EXV_CONSTS_SVH

// ==========================================================================
// Vector numbers (vector slots 5, 7 and 8 are reserved).
`define EXV_VEC_W        8
`define EXV_VEC_POR_PC   8'h00
`define EXV_VEC_POR_SP   8'h01
`define EXV_VEC_MAN_PC   8'h02
`define EXV_VEC_MAN_SP   8'h03
`define EXV_VEC_GEN_ILL  8'h04
`define EXV_VEC_SLOT_ILL 8'h06
`define EXV_VEC_CPU_AERR 8'h09
`define EXV_VEC_DMA_AERR 8'h0A
`define EXV_VEC_NMI      8'h0B
`define EXV_VEC_UBRK     8'h0C
`define EXV_VEC_FPU      8'h0D
`define EXV_VEC_DBG      8'h0E
`define EXV_VEC_BANK_OVF 8'h0F
`define EXV_VEC_BANK_UNF 8'h10

// ==========================================================================
// Table layout, sizes and reset values.
`define EXV_VEC_SHIFT    2
`define EXV_ADDR_W       32
`define EXV_BASE_RST     32'h0000_0000
`define EXV_NUM_SRC      8
`define EXV_NUM_GREGS    15
`define EXV_NUM_BANKS    15
`define EXV_BANK_IDX_W   4

`endif

// file: src/exv_pkg.sv
// Types shared by the exception vector and register bank unit.
`include "exv_consts.svh"

package exv_pkg;

  // ========================================================================
  // Vector fetch sequencer states.
  typedef enum logic [1:0] {
    EXV_ST_IDLE  = 2'b00,
    EXV_ST_RD_PC = 2'b01,
    EXV_ST_RD_SP = 2'b10
  } exv_state_e;

  // ========================================================================
  // One saved bank of core context.
  typedef struct packed {
    logic [`EXV_NUM_GREGS-1:0][31:0] general_regs;
    logic [31:0]                     global_base_reg;
    logic [31:0]                     multiply_acc_high;
    logic [31:0]                     multiply_acc_low;
    logic [31:0]                     subroutine_link_reg;
    logic [31:0]                     vector_offset_field;
  } exv_ctx_s;

  // Vector table read request towards memory.
  typedef struct packed {
    logic                   valid;
    logic [`EXV_ADDR_W-1:0] addr;
  } exv_rd_req_s;

  // Value loaded into a core register.
  typedef struct packed {
    logic        valid;
    logic [31:0] value;
  } exv_load_s;

endpackage : exv_pkg

// file: src/exv_bank_stack.sv
// Fifteen-deep last-in first-out stack of saved core context banks.
`timescale 1ns/1ps
`include "exv_consts.svh"

module exv_bank_stack #(
  parameter int NUM_BANKS = `EXV_NUM_BANKS,
  parameter int IDX_W     = `EXV_BANK_IDX_W
) (
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  input  wire logic              save_req,
  input  wire exv_pkg::exv_ctx_s save_ctx,
  input  wire logic              restore_req,
  output exv_pkg::exv_ctx_s      restore_ctx,
  output logic                   restore_valid,
  output logic                   overflow_pulse,
  output logic                   underflow_pulse,
  output logic [IDX_W-1:0]       bank_index
);

  // ========================================================================
  // Storage and state.
  exv_pkg::exv_ctx_s bank_mem [NUM_BANKS];
  exv_pkg::exv_ctx_s rctx_q, rctx_d;
  logic [IDX_W-1:0]  idx_q, idx_d;
  logic              rv_q, rv_d, ovf_q, ovf_d, unf_q, unf_d, we;

  localparam logic [IDX_W-1:0] FULL = IDX_W'(NUM_BANKS);

  // A save in the same cycle as a restore wins; the core never asks both.
  always_comb begin
    idx_d  = idx_q;
    rctx_d = rctx_q;
    rv_d   = 1'b0;
    ovf_d  = 1'b0;
    unf_d  = 1'b0;
    we     = 1'b0;
    if (save_req) begin
      if (idx_q == FULL) begin
        ovf_d = 1'b1;                       // see [RQ12]
      end else begin
        we    = 1'b1;                       // see [RQ10]
        idx_d = idx_q + 1'b1;               // see [RQ9]
      end
    end else if (restore_req) begin
      if (idx_q == '0) begin
        unf_d = 1'b1;                       // see [RQ12]
      end else begin
        idx_d  = idx_q - 1'b1;              // see [RQ8]
        rctx_d = bank_mem[idx_q - 1'b1];    // see [RQ9]
        rv_d   = 1'b1;
      end
    end
  end

  // Bank contents carry no reset; only the index decides what is valid.
  always_ff @(posedge ref_clk) begin
    if (we) begin
      bank_mem[idx_q] <= save_ctx;          // see [RQ6]
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      idx_q  <= '0;
      rctx_q <= '0;
      rv_q   <= 1'b0;
      ovf_q  <= 1'b0;
      unf_q  <= 1'b0;
    end else begin
      idx_q  <= idx_d;
      rctx_q <= rctx_d;
      rv_q   <= rv_d;
      ovf_q  <= ovf_d;
      unf_q  <= unf_d;
    end
  end

  assign restore_ctx     = rctx_q;
  assign restore_valid   = rv_q;
  assign overflow_pulse  = ovf_q;
  assign underflow_pulse = unf_q;
  assign bank_index      = idx_q;

  // ========================================================================
  // Checks.
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  a_bank_limit: assert property (idx_q <= FULL) // see [RQ7]
    else $error("bank index beyond last bank");
  a_save_incr: assert property (save_req && idx_q != FULL // see [RQ10]
    |=> idx_q == $past(idx_q) + 1'b1)
    else $error("save did not advance bank index");
  a_ovf_full: assert property (save_req && idx_q == FULL // see [RQ12]
    |=> ovf_q && $stable(idx_q))
    else $error("overflow not raised on full stack");
  a_unf_empty: assert property // see [RQ12]
    (!save_req && restore_req && idx_q == '0 |=> unf_q && !rv_q)
    else $error("underflow not raised on empty stack");
  a_restore_lifo: assert property // see [RQ8]
    (save_req && idx_q != FULL ##1 (restore_req && !save_req)
     |=> rv_q && rctx_q == $past(save_ctx, 2))
    else $error("restore did not return last saved bank");

endmodule : exv_bank_stack

// file: src/exv_top.sv
// Exception vector fetch sequencer with register bank stack.
`timescale 1ns/1ps
`include "exv_consts.svh"

// What this block does
// [RQ1] Software fills the vector table in memory before any exception.
// [RQ2] Each source has its own vector number and table offset.
// [RQ3] Handler address is read from the table entry and loaded as PC.
// [RQ4] Power-on reset loads PC/SP from vectors 0/1; manual from 2/3.
// [RQ5] Vector n sits at byte offset 4n; fixed source assignments.
// [RQ6] A bank save holds R0-R14, GLOBAL_BASE_REG, both MAC halves, PR, vector offset.
// [RQ7] Exactly fifteen banks, numbered 0 to 14.
// [RQ8] Banks form a stack; last saved is first restored.
// [RQ9] Saves fill upward from bank 0; restores go downward.
// [RQ10] Save goes to bank at current index, then index increments.
// [RQ11] Entry address is table base plus offset; base clears on reset.
// [RQ12] Save when full raises overflow; restore when empty raises underflow.

module exv_top #(
  parameter int ADDR_W = `EXV_ADDR_W
) (
  input  wire logic                        ref_clk,
  input  wire logic                        rst_n,
  input  wire logic                        base_wr,
  input  wire logic [ADDR_W-1:0]           base_wdata,
  input  wire logic                        man_reset_req,
  input  wire logic [`EXV_NUM_SRC-1:0]     exc_src,
  input  wire logic                        save_req,
  input  wire exv_pkg::exv_ctx_s           save_ctx,
  input  wire logic                        restore_req,
  input  wire logic                        mem_rd_valid,
  input  wire logic [31:0]                 mem_rd_data,
  output exv_pkg::exv_rd_req_s             mem_rd,
  output exv_pkg::exv_load_s               pc_load,
  output exv_pkg::exv_load_s               sp_load,
  output exv_pkg::exv_ctx_s                restore_ctx,
  output logic                             restore_valid,
  output logic [`EXV_BANK_IDX_W-1:0]       bank_index,
  output logic                             busy
);

  // ========================================================================
  // Source to vector map, index order is also acceptance priority.
  localparam logic [`EXV_VEC_W-1:0] SRC_VEC [`EXV_NUM_SRC] = '{
    `EXV_VEC_CPU_AERR, `EXV_VEC_DMA_AERR, `EXV_VEC_NMI, `EXV_VEC_UBRK,
    `EXV_VEC_DBG, `EXV_VEC_GEN_ILL, `EXV_VEC_SLOT_ILL, `EXV_VEC_FPU
  };

  // Entry address is the table base plus four bytes per vector.
  function automatic logic [ADDR_W-1:0] vec_addr(
    input logic [ADDR_W-1:0]     base,
    input logic [`EXV_VEC_W-1:0] v
  );
    vec_addr = base + (ADDR_W'(v) << `EXV_VEC_SHIFT); // see [RQ5]
  endfunction : vec_addr

  // Lowest set index of the pending sources.
  function automatic int first_src(input logic [`EXV_NUM_SRC-1:0] p);
    first_src = 0;
    for (int i = `EXV_NUM_SRC - 1; i >= 0; i--) begin
      if (p[i]) begin
        first_src = i;
      end
    end
  endfunction : first_src

  // ========================================================================
  // Sequencer state.
  exv_pkg::exv_state_e         st_q, st_d;
  exv_pkg::exv_rd_req_s        rd_q, rd_d;
  exv_pkg::exv_load_s          pc_q, pc_d, sp_q, sp_d;
  logic [ADDR_W-1:0]           base_q, base_d;
  logic [`EXV_VEC_W-1:0]       vec_q, vec_d;
  logic [`EXV_NUM_SRC-1:0]     pend_q, pend_d, take_src;
  logic                        fetch_sp_q, fetch_sp_d;
  logic                        povf_q, povf_d, punf_q, punf_d;
  logic                        man_q, man_d, busy_q, busy_d;
  logic                        take_ovf, take_unf, take_man;
  logic                        ovf_p, unf_p;
  logic                        start;
  logic [`EXV_VEC_W-1:0]       start_vec;
  int                          sel;

  // Bank stack raises overflow and underflow towards the sequencer.
  exv_bank_stack #(
    .NUM_BANKS (`EXV_NUM_BANKS),
    .IDX_W     (`EXV_BANK_IDX_W)
  ) u_banks (
    .ref_clk         (ref_clk),
    .rst_n           (rst_n),
    .save_req        (save_req),
    .save_ctx        (save_ctx),
    .restore_req     (restore_req),
    .restore_ctx     (restore_ctx),
    .restore_valid   (restore_valid),
    .overflow_pulse  (ovf_p),
    .underflow_pulse (unf_p),
    .bank_index      (bank_index)
  );

  // Requests are held pending so that none is lost while a fetch runs.
  // A new event in the cycle its pending bit is taken sets it again.
  always_comb begin
    st_d       = st_q;
    rd_d       = rd_q;
    vec_d      = vec_q;
    fetch_sp_d = fetch_sp_q;
    pc_d       = '{valid: 1'b0, value: pc_q.value};
    sp_d       = '{valid: 1'b0, value: sp_q.value};
    base_d     = base_wr ? base_wdata : base_q;   // see [RQ11]
    take_ovf   = 1'b0;
    take_unf   = 1'b0;
    take_man   = 1'b0;
    take_src   = '0;
    start      = 1'b0;
    start_vec  = `EXV_VEC_POR_PC;
    sel        = first_src(pend_q);
    case (st_q)
      exv_pkg::EXV_ST_IDLE: begin
        if (povf_q) begin
          take_ovf  = 1'b1;
          start     = 1'b1;
          start_vec = `EXV_VEC_BANK_OVF;          // see [RQ12]
        end else if (punf_q) begin
          take_unf  = 1'b1;
          start     = 1'b1;
          start_vec = `EXV_VEC_BANK_UNF;          // see [RQ12]
        end else if (man_q) begin
          take_man  = 1'b1;
          start     = 1'b1;
          start_vec = `EXV_VEC_MAN_PC;            // see [RQ4]
        end else if (pend_q != '0) begin
          take_src[sel] = 1'b1;
          start         = 1'b1;
          start_vec     = SRC_VEC[sel];           // see [RQ2]
        end
        if (start) begin
          vec_d      = start_vec;
          fetch_sp_d = take_man;
          rd_d       = '{valid: 1'b1,
                         addr: vec_addr(base_q, start_vec)}; // see [RQ11]
          st_d       = exv_pkg::EXV_ST_RD_PC;
        end
      end
      exv_pkg::EXV_ST_RD_PC: begin
        if (mem_rd_valid) begin
          pc_d = '{valid: 1'b1, value: mem_rd_data};  // see [RQ3]
          if (fetch_sp_q) begin
            vec_d = vec_q + 1'b1;                     // see [RQ4]
            rd_d  = '{valid: 1'b1,
                      addr: vec_addr(base_q, vec_q + 1'b1)};
            st_d  = exv_pkg::EXV_ST_RD_SP;
          end else begin
            rd_d.valid = 1'b0;
            st_d       = exv_pkg::EXV_ST_IDLE;
          end
        end
      end
      exv_pkg::EXV_ST_RD_SP: begin
        if (mem_rd_valid) begin
          sp_d       = '{valid: 1'b1, value: mem_rd_data}; // see [RQ4]
          rd_d.valid = 1'b0;
          fetch_sp_d = 1'b0;
          st_d       = exv_pkg::EXV_ST_IDLE;
        end
      end
      default: begin
        rd_d.valid = 1'b0;
        st_d       = exv_pkg::EXV_ST_IDLE;
      end
    endcase
    pend_d = (pend_q & ~take_src) | exc_src;
    povf_d = (povf_q & ~take_ovf) | ovf_p;
    punf_d = (punf_q & ~take_unf) | unf_p;
    man_d  = (man_q & ~take_man) | man_reset_req;
    busy_d = (st_d != exv_pkg::EXV_ST_IDLE);
  end

  // Reset starts the power-on fetch of vectors 0 and 1 at base zero.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      st_q       <= exv_pkg::EXV_ST_RD_PC;                 // see [RQ4]
      rd_q       <= '{valid: 1'b1, addr: `EXV_BASE_RST};   // see [RQ11]
      vec_q      <= `EXV_VEC_POR_PC;
      fetch_sp_q <= 1'b1;
      base_q     <= `EXV_BASE_RST;
      pc_q       <= '0;
      sp_q       <= '0;
      pend_q     <= '0;
      povf_q     <= 1'b0;
      punf_q     <= 1'b0;
      man_q      <= 1'b0;
      busy_q     <= 1'b1;
    end else begin
      st_q       <= st_d;
      rd_q       <= rd_d;
      vec_q      <= vec_d;
      fetch_sp_q <= fetch_sp_d;
      base_q     <= base_d;
      pc_q       <= pc_d;
      sp_q       <= sp_d;
      pend_q     <= pend_d;
      povf_q     <= povf_d;
      punf_q     <= punf_d;
      man_q      <= man_d;
      busy_q     <= busy_d;
    end
  end

  assign mem_rd  = rd_q;
  assign pc_load = pc_q;
  assign sp_load = sp_q;
  assign busy    = busy_q;

  // ========================================================================
  // Checks.
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  a_reset_fetch: assert property ($rose(rst_n) // see [RQ4]
    |-> rd_q.valid && rd_q.addr == '0 && vec_q == `EXV_VEC_POR_PC)
    else $error("reset fetch not from address zero");
  // The address was formed from the base as it stood when the fetch began.
  a_entry_addr: assert property ($rose(rd_q.valid) // see [RQ2]
    |-> rd_q.addr == $past(base_q) + (ADDR_W'(vec_q) << `EXV_VEC_SHIFT))
    else $error("entry address not base plus four times vector");
  a_pc_from_table: assert property // see [RQ3]
    (st_q == exv_pkg::EXV_ST_RD_PC && mem_rd_valid
     |=> pc_q.valid && pc_q.value == $past(mem_rd_data))
    else $error("handler address not loaded as PC");
  a_sp_follows: assert property // see [RQ4]
    (st_q == exv_pkg::EXV_ST_RD_PC && mem_rd_valid && fetch_sp_q
     |=> rd_q.valid
         && rd_q.addr == $past(rd_q.addr) + (ADDR_W'(1) << `EXV_VEC_SHIFT)
         ##[1:1000] sp_q.valid)
    else $error("stack pointer vector not fetched after PC");
  a_ovf_vector: assert property // see [RQ12]
    (ovf_p && st_q == exv_pkg::EXV_ST_IDLE && !povf_q && !punf_q
     |=> ##1 rd_q.valid && vec_q == `EXV_VEC_BANK_OVF)
    else $error("bank overflow vector not fetched");

endmodule : exv_top

// file: verification/exv_mem_model.sv
// Vector table memory model that answers the unit's table reads.
`timescale 1ns/1ps

module exv_mem_model (
  input  wire logic                 ref_clk,
  input  wire logic                 rst_n,
  input  wire exv_pkg::exv_rd_req_s mem_rd,
  input  wire logic [1:0]           lat,
  output logic                      mem_rd_valid,
  output logic [31:0]               mem_rd_data
);
  logic [1:0] wait_q;

  // ==========
  // Table contents
  // Every entry is preloaded, as software must do before any exception.
  function automatic logic [31:0] entry(input logic [31:0] a);
    return {a[15:0], ~a[15:0]};
  endfunction : entry

  // ==========
  // Answer logic
  // Answers after lat idle cycles; data flips outside an answer so stale
  // words can never be mistaken for a fresh table entry.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      mem_rd_valid <= 1'b0;
      mem_rd_data  <= 32'hA5A5_0F0F;
      wait_q       <= 2'h0;
    end else if (!mem_rd_valid && mem_rd.valid && wait_q >= lat) begin
      mem_rd_valid <= 1'b1;
      mem_rd_data  <= entry(mem_rd.addr);
      wait_q       <= 2'h0;
    end else begin
      mem_rd_valid <= 1'b0;
      mem_rd_data  <= ~mem_rd_data;
      if (mem_rd.valid && !mem_rd_valid) begin
        wait_q <= wait_q + 2'h1;
      end
    end
  end
endmodule : exv_mem_model

// file: verification/exv_top_tb.sv
// Self-checking testbench for the exception vector and bank unit.
`timescale 1ns/1ps
`include "exv_consts.svh"

module exv_top_tb;
  logic                 ref_clk;
  logic                 rst_n;
  logic                 base_wr;
  logic [31:0]          base_wdata;
  logic                 man_reset_req;
  logic [7:0]           exc_src;
  logic                 save_req;
  exv_pkg::exv_ctx_s    save_ctx;
  logic                 restore_req;
  logic                 mem_rd_valid;
  logic [31:0]          mem_rd_data;
  exv_pkg::exv_rd_req_s mem_rd;
  exv_pkg::exv_load_s   pc_load;
  exv_pkg::exv_load_s   sp_load;
  exv_pkg::exv_ctx_s    restore_ctx;
  logic                 restore_valid;
  logic [3:0]           bank_index;
  logic                 busy;
  logic [1:0]           lat;
  logic [31:0]          base;
  int                   bad_count;
  int                   num_checks;
  int                   cycles;
  exv_pkg::exv_ctx_s    saved [15];
  logic [7:0]           vec_tbl [8];

  exv_top exv_top_i (.ref_clk, .rst_n, .base_wr, .base_wdata, .man_reset_req,
    .exc_src, .save_req, .save_ctx, .restore_req, .mem_rd_valid, .mem_rd_data,
    .mem_rd, .pc_load, .sp_load, .restore_ctx, .restore_valid, .bank_index,
    .busy);
  exv_mem_model exv_mem_model_i (.ref_clk, .rst_n, .mem_rd, .lat,
    .mem_rd_valid, .mem_rd_data);

  // ==========
  // Clock and hang guard
  initial ref_clk = 1'b0;
  always #25 ref_clk = ~ref_clk;

  // Whole run needs well under a thousand cycles; the ceiling leaves a wide margin.
  always @(posedge ref_clk) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      bad_count = bad_count + 1;
      test_done();
    end
  end

  // ==========
  // Expectations and compares
  function automatic logic [31:0] entry(input logic [31:0] a);
    return {a[15:0], ~a[15:0]};
  endfunction : entry

  function automatic logic [31:0] addr_of(input logic [7:0] v);
    return base + {22'h0, v, 2'b00};
  endfunction : addr_of

  function automatic exv_pkg::exv_ctx_s rand_ctx();
    logic [639:0] v;
    for (int i = 0; i < 20; i++) v[i*32 +: 32] = $urandom;
    return v;
  endfunction : rand_ctx

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk32

  task automatic chk_ctx(input exv_pkg::exv_ctx_s got,
                         input exv_pkg::exv_ctx_s exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: restored context differs", $time);
    end
  endtask : chk_ctx

  // Polls at falling edges, so a one-cycle load pulse is never missed.
  task automatic wait_ld(input bit is_sp, input logic [31:0] exp);
    int n;
    exv_pkg::exv_load_s ld;
    n = 0;
    ld = is_sp ? sp_load : pc_load;
    while (ld.valid !== 1'b1 && n < 100) begin
      @(negedge ref_clk);
      ld = is_sp ? sp_load : pc_load;
      n++;
    end
    chk32({31'h0, ld.valid}, 32'h1, "load valid");
    chk32(ld.value, exp, "load value");
    // The stack pointer word ends a reset fetch, so the unit is idle then.
    if (is_sp) begin
      chk32({31'h0, busy}, 32'h0, "busy after sp");
    end
    @(negedge ref_clk);
  endtask : wait_ld

  // ==========
  // Drivers
  task automatic do_reset();
    @(posedge ref_clk);
    rst_n <= 1'b0;
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    base = 32'h0;
    @(negedge ref_clk);
    chk32({28'h0, bank_index}, 32'h0, "bank index");
    chk32({31'h0, busy}, 32'h1, "busy in reset fetch");
    wait_ld(1'b0, entry(32'h0));
    wait_ld(1'b1, entry(32'h4));
  endtask : do_reset

  task automatic set_base(input logic [31:0] b);
    @(posedge ref_clk);
    base_wr <= 1'b1;
    base_wdata <= b;
    @(posedge ref_clk);
    base_wr <= 1'b0;
    base = b;
  endtask : set_base

  task automatic pulse_src(input logic [7:0] s, input logic man);
    @(posedge ref_clk);
    exc_src <= s;
    man_reset_req <= man;
    @(posedge ref_clk);
    exc_src <= 8'h00;
    man_reset_req <= 1'b0;
    @(negedge ref_clk);
  endtask : pulse_src

  task automatic bank_op(input bit sv, input exv_pkg::exv_ctx_s c);
    @(posedge ref_clk);
    save_req <= sv;
    restore_req <= !sv;
    save_ctx <= c;
    @(posedge ref_clk);
    save_req <= 1'b0;
    restore_req <= 1'b0;
    @(negedge ref_clk);
  endtask : bank_op

  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : test_done

  // ==========
  // Main sequence
  initial begin
    {rst_n, base_wr, man_reset_req, save_req, restore_req} = 5'h00;
    base_wdata = 32'h0;
    exc_src = 8'h00;
    save_ctx = '0;
    lat = 2'h0;
    base = 32'h0;
    {bad_count, num_checks, cycles} = {32'h0, 32'h0, 32'h0};
    vec_tbl = '{`EXV_VEC_CPU_AERR, `EXV_VEC_DMA_AERR, `EXV_VEC_NMI,
      `EXV_VEC_UBRK, `EXV_VEC_DBG, `EXV_VEC_GEN_ILL, `EXV_VEC_SLOT_ILL,
      `EXV_VEC_FPU};
    void'($urandom(32'h36E6));
    do_reset();
    $display("test power_on done");
    // Random bases and memory speeds; the last burst stacks three events.
    for (int k = 0; k < 3; k++) begin
      lat <= 2'($urandom);
      set_base({24'($urandom), 8'h00});
      for (int i = 0; i < 8; i++) begin
        pulse_src(8'h01 << i, 1'b0);
        wait_ld(1'b0, entry(addr_of(vec_tbl[i])));
      end
      pulse_src(8'h81, 1'b1);
      wait_ld(1'b0, entry(addr_of(`EXV_VEC_MAN_PC)));
      wait_ld(1'b1, entry(addr_of(`EXV_VEC_MAN_SP)));
      wait_ld(1'b0, entry(addr_of(`EXV_VEC_CPU_AERR)));
      wait_ld(1'b0, entry(addr_of(`EXV_VEC_FPU)));
    end
    $display("test vectors done");
    for (int i = 0; i < 15; i++) begin
      saved[i] = rand_ctx();
      bank_op(1'b1, saved[i]);
      chk32({28'h0, bank_index}, i + 1, "bank index");
    end
    bank_op(1'b1, rand_ctx());
    chk32({28'h0, bank_index}, 32'hF, "bank index");
    wait_ld(1'b0, entry(addr_of(`EXV_VEC_BANK_OVF)));
    for (int i = 14; i >= 0; i--) begin
      bank_op(1'b0, rand_ctx());
      chk32({31'h0, restore_valid}, 32'h1, "restore valid");
      chk_ctx(restore_ctx, saved[i]);
      chk32({28'h0, bank_index}, i, "bank index");
    end
    bank_op(1'b0, rand_ctx());
    chk32({31'h0, restore_valid}, 32'h0, "restore valid");
    wait_ld(1'b0, entry(addr_of(`EXV_VEC_BANK_UNF)));
    // Save and restore on adjacent edges: the restore must see the new bank.
    saved[0] = rand_ctx();
    @(posedge ref_clk);
    save_req <= 1'b1;
    save_ctx <= saved[0];
    @(posedge ref_clk);
    save_req <= 1'b0;
    restore_req <= 1'b1;
    @(posedge ref_clk);
    restore_req <= 1'b0;
    @(negedge ref_clk);
    chk32({31'h0, restore_valid}, 32'h1, "restore valid");
    chk_ctx(restore_ctx, saved[0]);
    chk32({28'h0, bank_index}, 32'h0, "bank index");
    $display("test banks done");
    // Reset in mid-fetch must drop the base and refetch from zero.
    set_base({24'($urandom), 8'h00});
    bank_op(1'b1, rand_ctx());
    pulse_src(8'h04, 1'b0);
    do_reset();
    $display("test mid reset done");
    test_done();
  end
endmodule : exv_top_tb
